/* File: core/msel_top.sv */
// Modulation source selector: register port, source multiplexer and
// gating of the selected peripheral's own output pin.
// Assumes on-chip sources on CORE_CLK_I except comparator and mod pin.
`timescale 1ns/1ps
`default_nettype none
module msel_top
(
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       RESET_I,
  input  wire logic [msel_pkg::ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [msel_pkg::DATA_W-1:0] REG_WDATA_I,
  input  wire logic                       REG_WR_I,
  input  wire logic                       REG_RD_I,
  output logic      [msel_pkg::DATA_W-1:0] REG_RDATA_O,
  input  wire logic                       ASYNC_TX_I,
  input  wire logic                       SYNC_SDO_I,
  input  wire logic                       COMP_OUT_I,
  input  wire logic                       PWM_OUT_I,
  input  wire logic                       PWM_MODE_I,
  input  wire logic                       MOD_PIN_I,
  output logic                            MOD_SIGNAL_O,
  output logic                            PWM_PIN_O,
  output logic                            COMP_PIN_O,
  output logic                            SDO_PIN_O,
  output logic                            TX_PIN_O
);
  import msel_pkg::*;

  // Does the code name a connected channel
  function automatic logic code_valid(input logic [3:0] c);
    case (c)
      SEL_MANUAL, SEL_MOD_PIN, SEL_PWM,
      SEL_COMP, SEL_SYNC_SDO, SEL_ASYNC_TX: code_valid = 1'b1;
      default:                               code_valid = 1'b0;
    endcase
  endfunction

  logic       manual_r,  manual_nxt;
  logic       src_dis_r, src_dis_nxt;
  logic [3:0] src_sel_r, src_sel_nxt;
  logic [7:0] rdata_nxt;
  logic       mod_nxt;
  logic       comp_s, modpin_s;
  logic [NUM_PINS-1:0] pin_src, pin_r, pin_nxt;

  // Comparator and mod pin are not clocked by the core
  msel_sync2 u_sync_comp (
    .clk_i (CORE_CLK_I),
    .rst_i (RESET_I),
    .d_i   (COMP_OUT_I),
    .q_o   (comp_s)
  );
  msel_sync2 u_sync_pin (
    .clk_i (CORE_CLK_I),
    .rst_i (RESET_I),
    .d_i   (MOD_PIN_I),
    .q_o   (modpin_s)
  );

  always_comb begin
    manual_nxt  = manual_r;
    src_dis_nxt = src_dis_r;
    src_sel_nxt = src_sel_r;
    rdata_nxt   = 8'h00;
    if (REG_WR_I && REG_ADDR_I == MOD_CTRL_ADDR) begin
      manual_nxt = REG_WDATA_I[MANUAL_BIT_POS];
    end
    if (REG_WR_I && REG_ADDR_I == MOD_SRC_ADDR) begin
      src_dis_nxt = REG_WDATA_I[SRC_DIS_POS];
      src_sel_nxt = REG_WDATA_I[SRC_SEL_LSB +: SRC_SEL_W];
    end
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        MOD_CTRL_ADDR: rdata_nxt[MANUAL_BIT_POS] = manual_r;
        MOD_SRC_ADDR: begin
          rdata_nxt[SRC_DIS_POS]                   = src_dis_r;
          rdata_nxt[SRC_SEL_LSB +: SRC_SEL_W]      = src_sel_r;
        end
        default:       rdata_nxt = 8'h00;
      endcase
    end
  end

  // Source multiplexer; reserved codes leave the modulator input low
  always_comb begin
    case (src_sel_r)
      SEL_MANUAL:   mod_nxt = manual_r;
      SEL_MOD_PIN:  mod_nxt = modpin_s;
      SEL_PWM:      mod_nxt = PWM_OUT_I & PWM_MODE_I;
      SEL_COMP:     mod_nxt = comp_s;
      SEL_SYNC_SDO: mod_nxt = SYNC_SDO_I;
      SEL_ASYNC_TX: mod_nxt = ASYNC_TX_I;
      default:      mod_nxt = 1'b0;
    endcase
  end

  assign pin_src = {ASYNC_TX_I, SYNC_SDO_I, comp_s, PWM_OUT_I};

  generate
    for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      always_comb begin
        pin_nxt[g] = pin_src[g] &
                     ~(src_dis_r && src_sel_r == PIN_SEL[g]);
      end
    end
  endgenerate

  // Source register has no reset beyond power-on; RESET_I stands in for it
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      manual_r  <= MANUAL_RST;
      src_dis_r <= SRC_DIS_RST;
      src_sel_r <= SRC_SEL_RST;
    end else begin
      manual_r  <= manual_nxt;
      src_dis_r <= src_dis_nxt;
      src_sel_r <= src_sel_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      REG_RDATA_O  <= 8'h00;
      MOD_SIGNAL_O <= 1'b0;
      pin_r        <= '0;
    end else begin
      REG_RDATA_O  <= rdata_nxt;
      MOD_SIGNAL_O <= mod_nxt;
      pin_r        <= pin_nxt;
    end
  end

  always_comb begin
    PWM_PIN_O  = pin_r[PIN_PWM];
    COMP_PIN_O = pin_r[PIN_COMP];
    SDO_PIN_O  = pin_r[PIN_SDO];
    TX_PIN_O   = pin_r[PIN_TX];
  end

  a_tx_pin_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (src_dis_r && src_sel_r == SEL_ASYNC_TX) |=> !TX_PIN_O)
    else $error("TX pin driven while disabled");
  a_pwm_pin_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (src_dis_r && src_sel_r == SEL_PWM) |=> !PWM_PIN_O)
    else $error("PWM pin driven while disabled");
  a_comp_pin_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (src_dis_r && src_sel_r == SEL_COMP) |=> !COMP_PIN_O)
    else $error("comparator pin driven while disabled");
  a_sdo_pin_gate: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (src_dis_r && src_sel_r == SEL_SYNC_SDO) |=> !SDO_PIN_O)
    else $error("SDO pin driven while disabled");
  a_pin_pass: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (!src_dis_r) |=> SDO_PIN_O == $past(SYNC_SDO_I))
    else $error("SDO pin not passed through");
  a_tx_pin_pass: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    !(src_dis_r && src_sel_r == SEL_ASYNC_TX) |=>
      TX_PIN_O == $past(ASYNC_TX_I))
    else $error("TX pin not passed through");
  a_dis_write: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (REG_WR_I && REG_ADDR_I == MOD_SRC_ADDR) |=>
      src_dis_r == $past(REG_WDATA_I[SRC_DIS_POS]))
    else $error("disable bit not written");
  a_sel_write: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (REG_WR_I && REG_ADDR_I == MOD_SRC_ADDR) |=>
      src_sel_r == $past(REG_WDATA_I[3:0]))
    else $error("select field not written");
  a_src_readback: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (REG_RD_I && REG_ADDR_I == MOD_SRC_ADDR) |=>
      REG_RDATA_O == {$past(src_dis_r), 3'h0, $past(src_sel_r)})
    else $error("source register read back wrong");
  a_rdata_idle: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    !REG_RD_I |=> REG_RDATA_O == 8'h00)
    else $error("read data outside read cycle");
  // Synced inputs need two reset-free edges before the route is defined
  a_mod_pin: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (src_sel_r == SEL_MOD_PIN && !$past(RESET_I) && !$past(RESET_I, 2))
      |=> MOD_SIGNAL_O == $past(MOD_PIN_I, 3))
    else $error("mod pin not routed");
  a_comp_route: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (src_sel_r == SEL_COMP && !$past(RESET_I) && !$past(RESET_I, 2))
      |=> MOD_SIGNAL_O == $past(COMP_OUT_I, 3))
    else $error("comparator not routed");
  a_tx_route: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (src_sel_r == SEL_ASYNC_TX) |=> MOD_SIGNAL_O == $past(ASYNC_TX_I))
    else $error("async TX not routed");
  a_sdo_route: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (src_sel_r == SEL_SYNC_SDO) |=> MOD_SIGNAL_O == $past(SYNC_SDO_I))
    else $error("sync SDO not routed");
  a_pwm_pass: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (src_sel_r == SEL_PWM && PWM_MODE_I) |=>
      MOD_SIGNAL_O == $past(PWM_OUT_I))
    else $error("PWM not routed in PWM mode");
  a_pwm_route: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (src_sel_r == SEL_PWM && !PWM_MODE_I) |=> !MOD_SIGNAL_O)
    else $error("PWM routed outside PWM mode");
  a_reserved_low: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    !code_valid(src_sel_r) |=> !MOD_SIGNAL_O)
    else $error("reserved code drives modulator");
  a_manual_bit: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (REG_WR_I && REG_ADDR_I == MOD_CTRL_ADDR && src_sel_r == SEL_MANUAL
     && !(REG_WR_I && REG_ADDR_I == MOD_SRC_ADDR)) |=>
      ##1 MOD_SIGNAL_O == $past(REG_WDATA_I[0], 2))
    else $error("manual bit not on modulator");
  a_ctrl_readback: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    (REG_RD_I && REG_ADDR_I == MOD_CTRL_ADDR) |=>
      REG_RDATA_O == {7'h00, $past(manual_r)})
    else $error("control register read back wrong");
  a_sel_holds: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    !(REG_WR_I && REG_ADDR_I == MOD_SRC_ADDR) |=> $stable(src_sel_r))
    else $error("select changed without write");
  a_dis_holds: assert property (
    @(posedge CORE_CLK_I) disable iff (RESET_I)
    !(REG_WR_I && REG_ADDR_I == MOD_SRC_ADDR) |=> $stable(src_dis_r))
    else $error("disable bit changed without write");
  a_reset_clear: assert property (
    @(posedge CORE_CLK_I)
    RESET_I |=> (src_sel_r == SRC_SEL_RST && src_dis_r == SRC_DIS_RST &&
      manual_r == MANUAL_RST && !MOD_SIGNAL_O && REG_RDATA_O == 8'h00))
    else $error("reset values not loaded");
endmodule
`default_nettype wire

/* File: pkg/msel_pkg.sv */
// Constants for the modulation source selector: register map, fields,
// reset values and source select codes.
// Assumes an 8-bit register port with word-indexed addresses.
`default_nettype none
package msel_pkg;
  localparam int        ADDR_W         = 4;
  localparam int        DATA_W         = 8;
  localparam int        NUM_PINS       = 4;
  // Register indices
  localparam logic [3:0] MOD_CTRL_ADDR  = 4'h0;
  localparam logic [3:0] MOD_SRC_ADDR   = 4'h1;
  // Field positions
  localparam int        MANUAL_BIT_POS = 0;
  localparam int        SRC_DIS_POS    = 7;
  localparam int        SRC_SEL_LSB    = 0;
  localparam int        SRC_SEL_W      = 4;
  // Reset values
  localparam logic       MANUAL_RST     = 1'h0;
  localparam logic       SRC_DIS_RST    = 1'h0;
  localparam logic [3:0] SRC_SEL_RST    = 4'h0;
  // Source select codes
  localparam logic [3:0] SEL_MANUAL     = 4'h0;
  localparam logic [3:0] SEL_MOD_PIN    = 4'h1;
  localparam logic [3:0] SEL_PWM        = 4'h2;
  localparam logic [3:0] SEL_COMP       = 4'h6;
  localparam logic [3:0] SEL_SYNC_SDO   = 4'h8;
  localparam logic [3:0] SEL_ASYNC_TX   = 4'hA;
  // Pin output slots
  localparam int        PIN_PWM        = 0;
  localparam int        PIN_COMP       = 1;
  localparam int        PIN_SDO        = 2;
  localparam int        PIN_TX         = 3;
  localparam logic [3:0] PIN_SEL [NUM_PINS] =
    '{SEL_PWM, SEL_COMP, SEL_SYNC_SDO, SEL_ASYNC_TX};
endpackage
`default_nettype wire

/* File: core/msel_sync2.sv */
// Two-flop synchroniser for levels entering the core clock domain.
// Assumes the input is a slowly changing level.
`timescale 1ns/1ps
`default_nettype none
module msel_sync2 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  // First stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      q_o    <= q_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: tb/msel_sources.sv */
// Model of the on-chip peripherals that feed the source selector.
// Assumes the bench sets the wanted levels; they launch on a rising edge.
`timescale 1ns/1ps
`default_nettype none
module msel_sources (
  input  wire logic       clk_i,
  input  wire logic [5:0] lvl_i,
  output logic            tx_o,
  output logic            sdo_o,
  output logic            comp_o,
  output logic            pwm_o,
  output logic            mode_o,
  output logic            pin_o
);
  // Registered so every source changes just after an edge, as real ones do
  always_ff @(posedge clk_i) begin
    {pin_o, mode_o, pwm_o, comp_o, sdo_o, tx_o} <= lvl_i;
  end
endmodule
`default_nettype wire

/* File: tb/modulation_source_selector_test.sv */
// Self-checking bench for the source selector over its register port.
// Assumes the source model and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module modulation_source_selector_test;
  import msel_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [5:0] lvl = 6'h00;
  wire  [7:0] rdata;
  wire  [3:0] pins;
  wire        tx, sdo, comp, pwm, mode, mpin, mod;
  int         mismatches = 0, comparisons = 0;
  // Model levels that raise one source each, and the code that picks it
  logic [5:0] src_lvl [5] = '{6'h01, 6'h02, 6'h04, 6'h18, 6'h20};
  logic [3:0] src_code [5] =
    '{SEL_ASYNC_TX, SEL_SYNC_SDO, SEL_COMP, SEL_PWM, SEL_MOD_PIN};
  always #5 clk = ~clk;
  msel_sources i_msel_sources (.clk_i(clk), .lvl_i(lvl), .tx_o(tx),
    .sdo_o(sdo), .comp_o(comp), .pwm_o(pwm), .mode_o(mode), .pin_o(mpin));
  msel_top i_msel_top (.CORE_CLK_I(clk), .RESET_I(rst), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .ASYNC_TX_I(tx), .SYNC_SDO_I(sdo), .COMP_OUT_I(comp), .PWM_OUT_I(pwm),
    .PWM_MODE_I(mode), .MOD_PIN_I(mpin), .MOD_SIGNAL_O(mod),
    .PWM_PIN_O(pins[PIN_PWM]), .COMP_PIN_O(pins[PIN_COMP]),
    .SDO_PIN_O(pins[PIN_SDO]), .TX_PIN_O(pins[PIN_TX]));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Five edges cover the two-flop sync plus the output register
  task automatic sel(input logic [7:0] s);
    wr_reg(MOD_SRC_ADDR, s);
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(MOD_CTRL_ADDR, 8'h00);
    rd_reg(MOD_SRC_ADDR, 8'h00);
    wr_reg(MOD_CTRL_ADDR, 8'h01);
    lvl <= 6'h3F;
    for (int c = 0; c < 16; c++) begin
      sel(8'(c));
      chk({7'h0, mod}, (c inside {0, 1, 2, 6, 8, 10}) ? 8'h01 : 8'h00);
    end
    // Every source high, so only reserved codes may give a low
    sel(8'h0F);
    chk({7'h0, mod}, 8'h00);
    lvl <= 6'h2F;
    sel(8'h02);
    chk({7'h0, mod}, 8'h00);
    lvl <= 6'h00;
    sel(8'h0A);
    chk({7'h0, mod}, 8'h00);
    sel(8'h00);
    chk({7'h0, mod}, 8'h01);
    wr_reg(MOD_CTRL_ADDR, 8'h00);
    sel(8'h00);
    chk({7'h0, mod}, 8'h00);
    // One source high at a time, so a crossed route cannot hide
    for (int s = 0; s < 5; s++) begin
      lvl <= src_lvl[s];
      for (int c = 0; c < 16; c++) begin
        sel(8'(c));
        chk({7'h0, mod}, {7'h0, (4'(c) == src_code[s])});
      end
    end
    lvl <= 6'h3F;
    for (int k = 0; k < NUM_PINS; k++) begin
      sel({4'h8, PIN_SEL[k]});
      chk({4'h0, pins}, 8'h0F & ~(8'h01 << k));
      rd_reg(MOD_SRC_ADDR, {4'h8, PIN_SEL[k]});
    end
    sel(8'h7A);
    chk({4'h0, pins}, 8'h0F);
    rd_reg(MOD_SRC_ADDR, 8'h0A);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, 8'h00);
    rd_reg(MOD_SRC_ADDR, 8'h0A);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(MOD_SRC_ADDR, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
